/* logic/dtc_pkg.sv */
// dtc_pkg: register map, field positions, reset values and prescale figures of the dual timer block.
// assumes: shared by the timer top, the pin synchroniser and the prescaler; nothing is imported.
package dtc_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_PRESCALE = 8'h8E;

  // run and flag register layout
  localparam int POS_T1_OVF = 7;
  localparam int POS_T1_RUN = 6;
  localparam int POS_T0_OVF = 5;
  localparam int POS_T0_RUN = 4;
  localparam int POS_IRQ_B_FLAG = 3;
  localparam int POS_IRQ_B_TYPE = 2;
  localparam int POS_IRQ_A_FLAG = 1;
  localparam int POS_IRQ_A_TYPE = 0;

  // mode register layout
  localparam int POS_T1_GATE = 7;
  localparam int POS_T1_SRC = 6;
  localparam int POS_T1_MODE = 4;
  localparam int POS_T0_GATE = 3;
  localparam int POS_T0_SRC = 2;
  localparam int POS_T0_MODE = 0;

  // prescale control layout
  localparam int POS_T1_PRESCALE = 4;
  localparam int POS_T0_PRESCALE = 3;
  localparam logic [7:0] PRESCALE_RESET = 8'h01;
  localparam logic [7:0] PRESCALE_WMASK = 8'h3F;

  // other reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // count limits
  localparam int LOW5_WIDTH = 5;
  localparam logic [12:0] COUNT13_ALL_ONES = 13'h1FFF;
  localparam logic [15:0] COUNT16_ALL_ONES = 16'hFFFF;
  localparam logic [7:0] COUNT8_ALL_ONES = 8'hFF;

  // prescale ratios in cpu clocks per increment
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(DIV_SLOW - 1);
  localparam logic [1:0] FAST_LAST = 2'(DIV_FAST - 1);

  // synchronised pins
  localparam int PIN_COUNT = 4;
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 1;
  localparam int PIN_CNT_A = 2;
  localparam int PIN_CNT_B = 3;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_t;

endpackage : dtc_pkg

/* logic/dtc_prescaler.sv */
// dtc_prescaler: free running divide-by-12 counter giving a tick every 4 and every 12 cpu clocks.
// assumes: clk_sys is the cpu clock; ticks are one-cycle pulses read inside the timer top.
`timescale 1ns/1ps
module dtc_prescaler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // ticks
  output logic tick_fast,
  output logic tick_slow
);

  logic [3:0] phase;
  logic [3:0] next_phase;

  // 4 divides 12, so one counter serves both rates and keeps them aligned
  assign next_phase = (phase == dtc_pkg::PRESCALE_LAST) ? 4'h0 : phase + 4'h1;
  assign tick_fast = (phase[1:0] == dtc_pkg::FAST_LAST);
  assign tick_slow = (phase == dtc_pkg::PRESCALE_LAST);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase <= 4'h0;
    end else begin
      phase <= next_phase;
    end
  end

endmodule : dtc_prescaler

/* logic/dtc_pin_sync.sv */
// dtc_pin_sync: two-stage synchronisers with falling edge detect for the interrupt and count pins.
// assumes: pins idle high; outputs are read only in the clk_sys domain.
`timescale 1ns/1ps
module dtc_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // raw pins
  input wire logic [dtc_pkg::PIN_COUNT-1:0] pin_raw,
  // synchronised view
  output logic [dtc_pkg::PIN_COUNT-1:0] pin_level,
  output logic [dtc_pkg::PIN_COUNT-1:0] pin_fall
);

  logic [dtc_pkg::PIN_COUNT-1:0] meta;
  logic [dtc_pkg::PIN_COUNT-1:0] stage;
  logic [dtc_pkg::PIN_COUNT-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < dtc_pkg::PIN_COUNT; i++) begin : g_pin
      // meta feeds stage only; edges are judged on settled samples
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          meta[i] <= 1'b1;
          stage[i] <= 1'b1;
          prev[i] <= 1'b1;
        end else begin
          meta[i] <= pin_raw[i];
          stage[i] <= meta[i];
          prev[i] <= stage[i];
        end
      end
      assign pin_level[i] = stage[i];
      assign pin_fall[i] = prev[i] & ~stage[i];
    end
  endgenerate

endmodule : dtc_pin_sync

/* logic/dtc_timer_top.sv */
// dtc_timer_top: two 16-bit timer/counters with run/flag, mode and prescale registers and two external
// interrupt detectors, reached through the cpu special function register port.
// assumes: cpu core gives one-cycle write/read strobes and one-cycle acknowledges when it vectors.
`timescale 1ns/1ps
module dtc_timer_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // vectoring acknowledges
  input wire logic ack_first_timer,
  input wire logic ack_second_timer,
  input wire logic ack_ext_irq_a,
  input wire logic ack_ext_irq_b,
  // pins
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic first_timer_count_pin,
  input wire logic second_timer_count_pin,
  // interrupt requests
  output logic first_timer_overflow_flag,
  output logic second_timer_overflow_flag,
  output logic ext_irq_a_request_flag,
  output logic ext_irq_b_request_flag,
  // overflow pulses
  output logic first_timer_overflow_pulse,
  output logic second_timer_overflow_pulse
);

  logic first_timer_run_bit;
  logic second_timer_run_bit;
  logic ext_irq_a_type_select;
  logic ext_irq_b_type_select;
  logic [7:0] timer_mode_select_reg;
  logic [7:0] clock_prescale_control_reg;
  logic [7:0] first_timer_low_byte;
  logic [7:0] first_timer_high_byte;
  logic [7:0] second_timer_low_byte;
  logic [7:0] second_timer_high_byte;

  // pin synchronisers and prescaler
  logic [dtc_pkg::PIN_COUNT-1:0] pin_level;
  logic [dtc_pkg::PIN_COUNT-1:0] pin_fall;
  logic tick_fast;
  logic tick_slow;

  dtc_pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_raw({second_timer_count_pin, first_timer_count_pin, ext_irq_b_pin, ext_irq_a_pin}),
    .pin_level(pin_level),
    .pin_fall(pin_fall)
  );

  dtc_prescaler u_prescale (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick_fast(tick_fast),
    .tick_slow(tick_slow)
  );

  // register decode
  wire wr_run_flags = sfr_wr && (sfr_addr == dtc_pkg::ADDR_RUN_FLAGS);
  wire wr_mode_sel = sfr_wr && (sfr_addr == dtc_pkg::ADDR_MODE_SEL);
  wire wr_prescale = sfr_wr && (sfr_addr == dtc_pkg::ADDR_PRESCALE);
  wire wr_t0_low = sfr_wr && (sfr_addr == dtc_pkg::ADDR_T0_LOW);
  wire wr_t0_high = sfr_wr && (sfr_addr == dtc_pkg::ADDR_T0_HIGH);
  wire wr_t1_low = sfr_wr && (sfr_addr == dtc_pkg::ADDR_T1_LOW);
  wire wr_t1_high = sfr_wr && (sfr_addr == dtc_pkg::ADDR_T1_HIGH);

  // mode register fields
  wire dtc_pkg::dtc_mode_t mode_t0 = dtc_pkg::dtc_mode_t'(timer_mode_select_reg[dtc_pkg::POS_T0_MODE +: 2]);
  wire dtc_pkg::dtc_mode_t mode_t1 = dtc_pkg::dtc_mode_t'(timer_mode_select_reg[dtc_pkg::POS_T1_MODE +: 2]);
  wire gate_t0 = timer_mode_select_reg[dtc_pkg::POS_T0_GATE];
  wire gate_t1 = timer_mode_select_reg[dtc_pkg::POS_T1_GATE];
  wire src_pin_t0 = timer_mode_select_reg[dtc_pkg::POS_T0_SRC];
  wire src_pin_t1 = timer_mode_select_reg[dtc_pkg::POS_T1_SRC];

  // clock source per timer
  wire tick_t0 = clock_prescale_control_reg[dtc_pkg::POS_T0_PRESCALE] ? tick_fast : tick_slow;
  wire tick_t1 = clock_prescale_control_reg[dtc_pkg::POS_T1_PRESCALE] ? tick_fast : tick_slow;
  wire event_t0 = src_pin_t0 ? pin_fall[dtc_pkg::PIN_CNT_A] : tick_t0;
  wire event_t1 = src_pin_t1 ? pin_fall[dtc_pkg::PIN_CNT_B] : tick_t1;

  // gating: an asserted (low) irq pin holds a gated timer
  wire open_t0 = ~gate_t0 | pin_level[dtc_pkg::PIN_IRQ_A];
  wire open_t1 = ~gate_t1 | pin_level[dtc_pkg::PIN_IRQ_B];
  wire split_t0 = (mode_t0 == dtc_pkg::MODE_SPLIT);

  // increment enables
  wire inc_t0 = first_timer_run_bit & open_t0 & event_t0;
  wire inc_t0_high = split_t0 & second_timer_run_bit & tick_t0;
  // timer 0 split borrows the run bit, so timer 1 then runs on its mode alone
  wire run_t1 = split_t0 | second_timer_run_bit;
  wire inc_t1 = run_t1 & open_t1 & event_t1 & (mode_t1 != dtc_pkg::MODE_SPLIT);

  // one step of a timer: {overflow, next high, next low}
  function automatic logic [16:0] dtc_step(input logic [7:0] low, input logic [7:0] high,
                                           input dtc_pkg::dtc_mode_t mode);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] c8;
    logic wrap8;
    c13 = {high, low[dtc_pkg::LOW5_WIDTH-1:0]} + 13'h0001;
    c16 = {high, low} + 16'h0001;
    c8 = low + 8'h01;
    wrap8 = (low == dtc_pkg::COUNT8_ALL_ONES);
    case (mode)
      dtc_pkg::MODE_13BIT: begin
        // upper three low bits are left alone; software masks them
        dtc_step = {({high, low[dtc_pkg::LOW5_WIDTH-1:0]} == dtc_pkg::COUNT13_ALL_ONES),
                    c13[12:5], low[7:5], c13[4:0]};
      end
      dtc_pkg::MODE_16BIT: begin
        dtc_step = {({high, low} == dtc_pkg::COUNT16_ALL_ONES), c16};
      end
      dtc_pkg::MODE_RELOAD: begin
        dtc_step = {wrap8, high, (wrap8 ? high : c8)};
      end
      default: begin
        dtc_step = {wrap8, high, c8};
      end
    endcase
  endfunction : dtc_step

  wire [16:0] step_t0 = dtc_step(first_timer_low_byte, first_timer_high_byte, mode_t0);
  wire [16:0] step_t1 = dtc_step(second_timer_low_byte, second_timer_high_byte, mode_t1);
  wire ovf_t0 = inc_t0 & step_t0[16];
  wire ovf_t1 = inc_t1 & step_t1[16];
  wire ovf_t0_high = inc_t0_high & (first_timer_high_byte == dtc_pkg::COUNT8_ALL_ONES);

  // next counts; a cpu write to a byte wins over counting of that byte
  wire [7:0] high_t0_split = inc_t0_high ? first_timer_high_byte + 8'h01 : first_timer_high_byte;
  wire [7:0] next_t0_low = wr_t0_low ? sfr_wdata : (inc_t0 ? step_t0[7:0] : first_timer_low_byte);
  wire [7:0] next_t0_high = wr_t0_high ? sfr_wdata :
                            (split_t0 ? high_t0_split : (inc_t0 ? step_t0[15:8] : first_timer_high_byte));
  wire [7:0] next_t1_low = wr_t1_low ? sfr_wdata : (inc_t1 ? step_t1[7:0] : second_timer_low_byte);
  wire [7:0] next_t1_high = wr_t1_high ? sfr_wdata : (inc_t1 ? step_t1[15:8] : second_timer_high_byte);

  // overflow flags: a set in the same cycle as a clear wins
  wire set_ovf_t0 = ovf_t0;
  wire set_ovf_t1 = split_t0 ? ovf_t0_high : ovf_t1;
  wire keep_ovf_t0 = wr_run_flags ? sfr_wdata[dtc_pkg::POS_T0_OVF] : first_timer_overflow_flag;
  wire keep_ovf_t1 = wr_run_flags ? sfr_wdata[dtc_pkg::POS_T1_OVF] : second_timer_overflow_flag;
  wire next_ovf_t0 = set_ovf_t0 | (~ack_first_timer & keep_ovf_t0);
  wire next_ovf_t1 = set_ovf_t1 | (~ack_second_timer & keep_ovf_t1);

  // external requests: type select 1 edge, 0 level
  wire next_type_a = wr_run_flags ? sfr_wdata[dtc_pkg::POS_IRQ_A_TYPE] : ext_irq_a_type_select;
  wire next_type_b = wr_run_flags ? sfr_wdata[dtc_pkg::POS_IRQ_B_TYPE] : ext_irq_b_type_select;
  wire set_irq_a = ext_irq_a_type_select & pin_fall[dtc_pkg::PIN_IRQ_A];
  wire set_irq_b = ext_irq_b_type_select & pin_fall[dtc_pkg::PIN_IRQ_B];
  // software may only clear an edge request; writing 1 keeps the current value
  wire sw_keep_a = ~wr_run_flags | sfr_wdata[dtc_pkg::POS_IRQ_A_FLAG];
  wire sw_keep_b = ~wr_run_flags | sfr_wdata[dtc_pkg::POS_IRQ_B_FLAG];
  wire edge_irq_a = set_irq_a | (ext_irq_a_request_flag & sw_keep_a & ~ack_ext_irq_a);
  wire edge_irq_b = set_irq_b | (ext_irq_b_request_flag & sw_keep_b & ~ack_ext_irq_b);
  wire next_irq_a = ext_irq_a_type_select ? edge_irq_a : ~pin_level[dtc_pkg::PIN_IRQ_A];
  wire next_irq_b = ext_irq_b_type_select ? edge_irq_b : ~pin_level[dtc_pkg::PIN_IRQ_B];

  // read view of the run and flag register
  logic [7:0] run_flags_view;
  assign run_flags_view[dtc_pkg::POS_T1_OVF] = second_timer_overflow_flag;
  assign run_flags_view[dtc_pkg::POS_T1_RUN] = second_timer_run_bit;
  assign run_flags_view[dtc_pkg::POS_T0_OVF] = first_timer_overflow_flag;
  assign run_flags_view[dtc_pkg::POS_T0_RUN] = first_timer_run_bit;
  assign run_flags_view[dtc_pkg::POS_IRQ_B_FLAG] = ext_irq_b_request_flag;
  assign run_flags_view[dtc_pkg::POS_IRQ_B_TYPE] = ext_irq_b_type_select;
  assign run_flags_view[dtc_pkg::POS_IRQ_A_FLAG] = ext_irq_a_request_flag;
  assign run_flags_view[dtc_pkg::POS_IRQ_A_TYPE] = ext_irq_a_type_select;

  // unmapped addresses read as zero
  wire [7:0] read_mux =
    (sfr_addr == dtc_pkg::ADDR_RUN_FLAGS) ? run_flags_view :
    (sfr_addr == dtc_pkg::ADDR_MODE_SEL) ? timer_mode_select_reg :
    (sfr_addr == dtc_pkg::ADDR_PRESCALE) ? clock_prescale_control_reg :
    (sfr_addr == dtc_pkg::ADDR_T0_LOW) ? first_timer_low_byte :
    (sfr_addr == dtc_pkg::ADDR_T0_HIGH) ? first_timer_high_byte :
    (sfr_addr == dtc_pkg::ADDR_T1_LOW) ? second_timer_low_byte :
    (sfr_addr == dtc_pkg::ADDR_T1_HIGH) ? second_timer_high_byte : dtc_pkg::BYTE_RESET;

  // control registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_timer_run_bit <= 1'b0;
      second_timer_run_bit <= 1'b0;
      ext_irq_a_type_select <= 1'b0;
      ext_irq_b_type_select <= 1'b0;
      timer_mode_select_reg <= dtc_pkg::BYTE_RESET;
      clock_prescale_control_reg <= dtc_pkg::PRESCALE_RESET;
      sfr_rdata <= dtc_pkg::BYTE_RESET;
    end else begin
      if (wr_run_flags) begin
        first_timer_run_bit <= sfr_wdata[dtc_pkg::POS_T0_RUN];
        second_timer_run_bit <= sfr_wdata[dtc_pkg::POS_T1_RUN];
      end
      ext_irq_a_type_select <= next_type_a;
      ext_irq_b_type_select <= next_type_b;
      if (wr_mode_sel) begin
        timer_mode_select_reg <= sfr_wdata;
      end
      if (wr_prescale) begin
        clock_prescale_control_reg <= sfr_wdata & dtc_pkg::PRESCALE_WMASK;
      end
      if (sfr_rd) begin
        sfr_rdata <= read_mux;
      end
    end
  end

  // counts
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_timer_low_byte <= dtc_pkg::BYTE_RESET;
      first_timer_high_byte <= dtc_pkg::BYTE_RESET;
      second_timer_low_byte <= dtc_pkg::BYTE_RESET;
      second_timer_high_byte <= dtc_pkg::BYTE_RESET;
    end else begin
      first_timer_low_byte <= next_t0_low;
      first_timer_high_byte <= next_t0_high;
      second_timer_low_byte <= next_t1_low;
      second_timer_high_byte <= next_t1_high;
    end
  end

  // flags and pulses
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_timer_overflow_flag <= 1'b0;
      second_timer_overflow_flag <= 1'b0;
      ext_irq_a_request_flag <= 1'b0;
      ext_irq_b_request_flag <= 1'b0;
      first_timer_overflow_pulse <= 1'b0;
      second_timer_overflow_pulse <= 1'b0;
    end else begin
      first_timer_overflow_flag <= next_ovf_t0;
      second_timer_overflow_flag <= next_ovf_t1;
      ext_irq_a_request_flag <= next_irq_a;
      ext_irq_b_request_flag <= next_irq_b;
      first_timer_overflow_pulse <= ovf_t0;
      second_timer_overflow_pulse <= ovf_t1;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_ovf_t0;
    inc_t0 && step_t0[16];
  endsequence

  sequence s_pulse_once;
    first_timer_overflow_pulse ##1 !first_timer_overflow_pulse;
  endsequence

  a_ovf_flag_set:
    assert property (s_ovf_t0 |=> first_timer_overflow_flag)
      else $error("timer 0 overflow did not set its flag");

  a_ack_clears_flag:
    assert property (ack_second_timer && !set_ovf_t1 |=> !second_timer_overflow_flag)
      else $error("acknowledge did not clear timer 1 flag");

  a_stopped_holds:
    assert property (!first_timer_run_bit && !wr_t0_low |=> $stable(first_timer_low_byte))
      else $error("timer 0 low byte moved while stopped");

  a_gate_blocks:
    assert property (gate_t0 && !pin_level[dtc_pkg::PIN_IRQ_A] && !wr_t0_low |=> $stable(first_timer_low_byte))
      else $error("gated timer 0 counted with pin asserted");

  a_pulse_one_cycle:
    assert property (s_ovf_t0 |=> s_pulse_once)
      else $error("overflow pulse not exactly one cycle");

  a_reload_value:
    assert property (inc_t0 && mode_t0 == dtc_pkg::MODE_RELOAD && first_timer_low_byte == dtc_pkg::COUNT8_ALL_ONES
                     && !wr_t0_low
                     |=> first_timer_low_byte == $past(first_timer_high_byte))
      else $error("mode 2 reload value wrong");

  a_t1_split_hold:
    assert property (mode_t1 == dtc_pkg::MODE_SPLIT && !wr_t1_low && !wr_t1_high
                     |=> $stable({second_timer_high_byte, second_timer_low_byte}))
      else $error("timer 1 moved in mode 3");

  a_level_mirror_a:
    assert property (!ext_irq_a_type_select |=> ext_irq_a_request_flag == !$past(pin_level[dtc_pkg::PIN_IRQ_A]))
      else $error("irq a level flag does not mirror pin");

  a_level_mirror_b:
    assert property (!ext_irq_b_type_select |=> ext_irq_b_request_flag == !$past(pin_level[dtc_pkg::PIN_IRQ_B]))
      else $error("irq b level flag does not mirror pin");

  a_edge_sets_b:
    assert property (ext_irq_b_type_select && pin_fall[dtc_pkg::PIN_IRQ_B] |=> ext_irq_b_request_flag)
      else $error("irq b edge did not set flag");

  a_edge_sets_a:
    assert property (ext_irq_a_type_select && pin_fall[dtc_pkg::PIN_IRQ_A] |=> ext_irq_a_request_flag)
      else $error("irq a edge did not set flag");

endmodule : dtc_timer_top

/* sim/dtc_cpu_model.sv */
// dtc_cpu_model: behavioural cpu core driving the register port and the vectoring acknowledges.
// assumes: requests change at falling edges of clk_sys and stand across exactly one rising edge.
`timescale 1ns/1ps
module dtc_cpu_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // acknowledges: first timer, second timer, irq a, irq b
  output logic [3:0] ack
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    ack = 4'h0;
  end
  // idle bus shows the inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask : rd
  // one-cycle vectoring pulse per source
  task automatic vector(input int idx);
    @(negedge clk_sys);
    ack[idx] = 1'b1;
    @(negedge clk_sys);
    ack = 4'h0;
  endtask : vector
endmodule : dtc_cpu_model

/* sim/dual_timer_counter_ext_irq_bench.sv */
// dual_timer_counter_ext_irq_bench: self-checking bench of the dual timer block.
// assumes: the cpu model owns the register port; pins are driven here at falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module dual_timer_counter_ext_irq_bench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic irq_a = 1'b1, irq_b = 1'b1, cnt_a = 1'b1, cnt_b = 1'b1;
  logic [7:0] addr, wdata, rdata, r, r2;
  logic wr, rd, f0, f1, fa, fb, p0, p1;
  logic [3:0] ack;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] md [3] = '{8'h00, 8'h01, 8'h02};
  logic [7:0] hi [3] = '{8'hFF, 8'hFF, 8'hF0};
  logic [7:0] lo [3] = '{8'h1F, 8'hFE, 8'hFF};
  logic [7:0] ra [3] = '{dtc_pkg::ADDR_T0_HIGH, dtc_pkg::ADDR_T0_LOW, dtc_pkg::ADDR_T0_LOW};
  logic [7:0] ex [3] = '{8'h00, 8'h00, 8'hF0};
  dtc_cpu_model i_cpu (.clk_sys(clk_sys), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .ack(ack));
  dtc_timer_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .ack_first_timer(ack[0]), .ack_second_timer(ack[1]),
    .ack_ext_irq_a(ack[2]), .ack_ext_irq_b(ack[3]), .ext_irq_a_pin(irq_a), .ext_irq_b_pin(irq_b),
    .first_timer_count_pin(cnt_a), .second_timer_count_pin(cnt_b), .first_timer_overflow_flag(f0),
    .second_timer_overflow_flag(f1), .ext_irq_a_request_flag(fa), .ext_irq_b_request_flag(fb),
    .first_timer_overflow_pulse(p0), .second_timer_overflow_pulse(p1));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // returns at the falling edge where the pulse stands, or after lim cycles
  task automatic wait_pulse(input int lim);
    int i;
    i = 0;
    while (p0 !== 1'b1 && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK("pulse0", 1'b1, p0)
  endtask : wait_pulse
  task automatic t_regs();
    i_cpu.rd(dtc_pkg::ADDR_RUN_FLAGS, r);
    `CHK("flags reset", 8'h00, r)
    i_cpu.rd(dtc_pkg::ADDR_MODE_SEL, r);
    `CHK("mode reset", 8'h00, r)
    i_cpu.rd(dtc_pkg::ADDR_PRESCALE, r);
    `CHK("prescale reset", 8'h01, r)
    i_cpu.rd(8'h90, r);
    `CHK("unmapped", 8'h00, r)
  endtask : t_regs
  task automatic t_roll();
    i_cpu.wr(dtc_pkg::ADDR_PRESCALE, 8'h09);
    for (int k = 0; k < 3; k++) begin
      i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      i_cpu.wr(dtc_pkg::ADDR_MODE_SEL, md[k]);
      i_cpu.wr(dtc_pkg::ADDR_T0_HIGH, hi[k]);
      i_cpu.wr(dtc_pkg::ADDR_T0_LOW, lo[k]);
      i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
      wait_pulse(40);
      `CHK("flag0 set", 1'b1, f0)
      @(negedge clk_sys);
      `CHK("pulse0 one cycle", 1'b0, p0)
      i_cpu.rd(ra[k], r);
      `CHK("rolled count", ex[k], r)
      i_cpu.vector(0);
      `CHK("flag0 cleared", 1'b0, f0)
    end
  endtask : t_roll
  task automatic t_rate();
    int i;
    i_cpu.wr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
    // reload of all ones makes every tick an overflow, so pulse spacing is the tick spacing
    i_cpu.wr(dtc_pkg::ADDR_T0_LOW, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      i_cpu.wr(dtc_pkg::ADDR_PRESCALE, k ? 8'h09 : 8'h01);
      wait_pulse(40);
      i = 0;
      do begin
        @(negedge clk_sys);
        i++;
      end while (p0 !== 1'b1 && i < 40);
      `CHK("tick spacing", k ? 4 : 12, i)
    end
  endtask : t_rate
  task automatic t_gate();
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    i_cpu.wr(dtc_pkg::ADDR_MODE_SEL, 8'h09);
    i_cpu.wr(dtc_pkg::ADDR_T0_LOW, 8'h00);
    irq_a = 1'b0;
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
    repeat (30) @(negedge clk_sys);
    `CHK("level a low", 1'b1, fa)
    i_cpu.rd(dtc_pkg::ADDR_T0_LOW, r);
    `CHK("gated count", 8'h00, r)
    irq_a = 1'b1;
    repeat (30) @(negedge clk_sys);
    `CHK("level a high", 1'b0, fa)
    i_cpu.rd(dtc_pkg::ADDR_T0_LOW, r);
    `CHK("gate open", 1'b1, r != 8'h00)
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    i_cpu.rd(dtc_pkg::ADDR_T0_LOW, r);
    repeat (30) @(negedge clk_sys);
    i_cpu.rd(dtc_pkg::ADDR_T0_LOW, r2);
    `CHK("run off holds", r, r2)
  endtask : t_gate
  task automatic t_edge();
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h05);
    irq_b = 1'b0;
    irq_a = 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK("edge b", 1'b1, fb)
    `CHK("edge a", 1'b1, fa)
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h0F);
    `CHK("write 1 keeps", 1'b1, fb)
    i_cpu.vector(3);
    `CHK("ack b", 1'b0, fb)
    i_cpu.vector(2);
    `CHK("ack a", 1'b0, fa)
    irq_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    irq_b = 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK("edge b again", 1'b1, fb)
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h04);
    `CHK("soft clear b", 1'b0, fb)
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    repeat (5) @(negedge clk_sys);
    `CHK("level b low", 1'b1, fb)
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    `CHK("level write ignored", 1'b1, fb)
    irq_b = 1'b1;
    irq_a = 1'b1;
    repeat (5) @(negedge clk_sys);
    `CHK("level b high", 1'b0, fb)
  endtask : t_edge
  task automatic t_count();
    i_cpu.wr(dtc_pkg::ADDR_MODE_SEL, 8'h05);
    i_cpu.wr(dtc_pkg::ADDR_T0_LOW, 8'h00);
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
    repeat (3) begin
      cnt_a = 1'b0;
      repeat (3) @(negedge clk_sys);
      cnt_a = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
    i_cpu.rd(dtc_pkg::ADDR_T0_LOW, r);
    `CHK("pin edges", 8'h03, r)
  endtask : t_count
  task automatic t_split();
    int i;
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    i_cpu.wr(dtc_pkg::ADDR_MODE_SEL, 8'h33);
    i_cpu.wr(dtc_pkg::ADDR_T1_LOW, 8'h55);
    i_cpu.wr(dtc_pkg::ADDR_T0_HIGH, 8'hFE);
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h40);
    i = 0;
    while (f1 !== 1'b1 && i < 100) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK("split high flag", 1'b1, f1)
    i_cpu.rd(dtc_pkg::ADDR_T1_LOW, r);
    `CHK("timer1 held", 8'h55, r)
    i_cpu.vector(1);
    `CHK("flag1 cleared", 1'b0, f1)
    // timer 1 back in mode 1 runs on its mode alone; its overflow pulses but the flag stays with the split byte
    i_cpu.wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    i_cpu.wr(dtc_pkg::ADDR_T1_HIGH, 8'hFF);
    i_cpu.wr(dtc_pkg::ADDR_T1_LOW, 8'hFF);
    i_cpu.wr(dtc_pkg::ADDR_MODE_SEL, 8'h13);
    i = 0;
    while (p1 !== 1'b1 && i < 40) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK("timer1 runs in split", 1'b1, p1)
    `CHK("split keeps flag1", 1'b0, f1)
    i_cpu.rd(dtc_pkg::ADDR_T1_LOW, r);
    `CHK("timer1 rolled", 8'h00, r)
  endtask : t_split
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    t_regs();
    t_roll();
    t_rate();
    t_gate();
    t_edge();
    t_count();
    t_split();
    print_verdict();
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule : dual_timer_counter_ext_irq_bench
